// file: hw/sqa_pkg.sv
// Shared constants and helpers for the SRAM service-level arbiter
package sqa_pkg;

	localparam int NUM_PORTS = 5;
	localparam int ID_W      = 3;
	localparam int LVL_W     = 2;

	typedef logic [LVL_W-1:0] sqa_level_t;
	typedef logic [ID_W-1:0]  sqa_id_t;

	// Static port numbers, lower number wins ties
	localparam sqa_id_t PORT_CPU   = 3'h0;
	localparam sqa_id_t PORT_TRACE = 3'h1;
	localparam sqa_id_t PORT_DEBUG = 3'h2;
	localparam sqa_id_t PORT_USB   = 3'h3;
	localparam sqa_id_t PORT_DMA   = 3'h4;

	// Service level encodings
	localparam sqa_level_t LVL_DISABLE  = 2'h0;
	localparam sqa_level_t LVL_LOW      = 2'h1;
	localparam sqa_level_t LVL_MEDIUM   = 2'h2;
	localparam sqa_level_t LVL_HIGH     = 2'h3;
	localparam sqa_level_t LVL_TRACE    = LVL_HIGH;
	localparam sqa_level_t LVL_DEBUG    = LVL_LOW;
	localparam sqa_level_t CPU_LVL_RST  = 2'h0;

	// Register byte addresses
	localparam logic [31:0] ADDR_CPU_LVL = 32'h4100_7110;
	localparam logic [31:0] ADDR_STATUS  = 32'h4100_7114;

	// Status field layout
	localparam int STAT_ID_LSB  = 0;
	localparam int STAT_VLD_BIT = 3;

	// Levels that must wait at least one cycle
	function automatic logic sqa_is_slow(input sqa_level_t lvl);
		return (lvl == LVL_DISABLE) || (lvl == LVL_LOW);
	endfunction

endpackage

// file: hw/sqa_cfg_if.sv
// Configuration and status bundle between register block and core
`timescale 1ns/1ps
interface sqa_cfg_if;
	import sqa_pkg::*;

	sqa_level_t cpu_level;
	sqa_id_t    last_id;
	logic       last_vld;

	modport regs (
		output cpu_level,
		input  last_id,
		input  last_vld
	);

	modport core (
		input  cpu_level,
		output last_id,
		output last_vld
	);

endinterface

// file: hw/sqa_apb_regs.sv
// APB slave holding the processor service level and status view
`timescale 1ns/1ps
module sqa_apb_regs
	import sqa_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	sqa_cfg_if.regs          cfg
);

	sqa_level_t  cpu_lvl_r;
	logic [31:0] prdata_r;
	logic [31:0] rd_val;

	wire hit_lvl  = (paddr == ADDR_CPU_LVL);
	wire hit_stat = (paddr == ADDR_STATUS);
	wire hit_any  = hit_lvl | hit_stat;
	wire setup    = psel & ~penable;
	wire access   = psel & penable;
	wire wr_lvl   = access & pwrite & hit_lvl & pstrb[0];

	assign rd_val = hit_lvl ? {30'h0, cpu_lvl_r} :
		hit_stat ? {28'h0, cfg.last_vld, cfg.last_id} : 32'h0;

	assign pready        = 1'b1;
	assign pslverr       = access & ~hit_any;
	assign prdata        = prdata_r;
	assign cfg.cpu_level = cpu_lvl_r;

	////////////////////////////////////////////////////////////////////////
	// processor level field
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cpu_lvl_r <= CPU_LVL_RST;
		else if (wr_lvl)
			cpu_lvl_r <= pwdata[LVL_W-1:0];
	end

	// Read data captured in setup
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			prdata_r <= 32'h0;
		else if (setup)
			prdata_r <= rd_val;
	end

endmodule

// file: hw/sqa_pick.sv
// Two-key selector: highest level first, then lowest port
`timescale 1ns/1ps
module sqa_pick
	import sqa_pkg::*;
#(
	parameter int N = NUM_PORTS
) (
	input  wire logic [N-1:0]       elig,
	input  wire logic [N*LVL_W-1:0] lvl,
	output logic      [N-1:0]       gnt,
	output sqa_id_t                 gnt_id,
	output logic                    gnt_vld
);

	sqa_level_t best_lvl;

	always_comb begin
		gnt      = '0;
		gnt_id   = '0;
		gnt_vld  = 1'b0;
		best_lvl = LVL_DISABLE;
		for (int i = N - 1; i >= 0; i--) begin
			if (elig[i] && (!gnt_vld ||
				lvl[i*LVL_W +: LVL_W] >= best_lvl)) begin
				gnt_vld  = 1'b1;
				gnt_id   = ID_W'(i);
				best_lvl = lvl[i*LVL_W +: LVL_W];
			end
		end
		if (gnt_vld)
			gnt[gnt_id] = 1'b1;
	end

endmodule

// file: hw/sqa_arbiter.sv
// SRAM port arbiter top with service-level ordering and APB registers
// Operation
// - Levels 0 and 1 wait at least one clock before grant.
// - Highest service level wins; port order only breaks ties.
// - Equal levels: lowest-numbered port wins.
// - Trace buffer fixed at level 3, debug fixed at level 1.
// - Processor level is a 2-bit software field, resets to zero.
// - USB and DMA levels come from their own control fields.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module sqa_arbiter
	import sqa_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [NUM_PORTS-1:0] req,
	input  wire sqa_level_t           usb_level,
	input  wire sqa_level_t           dma_level,
	output logic      [NUM_PORTS-1:0] gnt
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	sqa_cfg_if cfg ();

	sqa_apb_regs u_regs (
		.clk     (clk),
		.arst_n  (arst_n),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.cfg     (cfg.regs)
	);

	////////////////////////////////////////////////////////////////////////
	// Level assembly

	logic [NUM_PORTS*LVL_W-1:0] lvl;
	logic [NUM_PORTS-1:0]       waited_r;
	logic [NUM_PORTS-1:0]       waited_nxt;
	logic [NUM_PORTS-1:0]       slow;
	logic [NUM_PORTS-1:0]       elig;
	sqa_id_t                    pick_id;
	logic                       pick_vld;
	sqa_id_t                    last_id_r;
	logic                       last_vld_r;

	assign lvl[PORT_CPU*LVL_W +: LVL_W]   = cfg.cpu_level;
	assign lvl[PORT_TRACE*LVL_W +: LVL_W] = LVL_TRACE;
	assign lvl[PORT_DEBUG*LVL_W +: LVL_W] = LVL_DEBUG;
	assign lvl[PORT_USB*LVL_W +: LVL_W]   = usb_level;
	assign lvl[PORT_DMA*LVL_W +: LVL_W]   = dma_level;

	////////////////////////////////////////////////////////////////////////
	// Latency gate

	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : g_gate
			assign slow[g] = sqa_is_slow(lvl[g*LVL_W +: LVL_W]);
			assign elig[g] = req[g] & (~slow[g] | waited_r[g]);
		end
	endgenerate

	assign waited_nxt = req & ~gnt;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			waited_r <= '0;
		else
			waited_r <= waited_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Selection

	sqa_pick #(
		.N (NUM_PORTS)
	) u_pick (
		.elig    (elig),
		.lvl     (lvl),
		.gnt     (gnt),
		.gnt_id  (pick_id),
		.gnt_vld (pick_vld)
	);

	////////////////////////////////////////////////////////////////////////
	// Status capture

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			last_id_r  <= '0;
			last_vld_r <= 1'b0;
		end else begin
			last_vld_r <= pick_vld;
			if (pick_vld)
				last_id_r <= pick_id;
		end
	end

	assign cfg.last_id  = last_id_r;
	assign cfg.last_vld = last_vld_r;

endmodule

// file: test/sqa_arbiter_sva.sv
// Port assertions for the SRAM arbiter
`timescale 1ns/1ps
module sqa_arbiter_sva
	import sqa_pkg::*;
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic [4:0]  req,
	input wire sqa_level_t  usb_level,
	input wire sqa_level_t  dma_level,
	input wire logic [4:0]  gnt
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	one_grant_a: assert property ($onehot0(gnt))
		else $error("two grants");
	grant_req_a: assert property ((gnt & ~req) == '0)
		else $error("grant without request");
	trace_wins_a: assert property (req[1] && !gnt[0] |-> gnt[1])
		else $error("trace port passed over");
	slow_wait_a: assert property (
		!$past(req[2] && !gnt[2]) |-> !gnt[2])
		else $error("debug port served without wait");
	slow_done_a: assert property (
		$past(req[2] && !gnt[2]) && req == 5'h04 |-> gnt[2])
		else $error("debug port not served");
	usb_dma_a: assert property (gnt[4] |->
		!(req[3] && usb_level[1] && usb_level >= dma_level))
		else $error("dma beat usb");
	fast_grant_a: assert property (
		req == 5'h10 && dma_level[1] |-> gnt[4])
		else $error("urgent dma delayed");
	bad_addr_a: assert property (psel && penable &&
		paddr != ADDR_CPU_LVL && paddr != ADDR_STATUS |-> pslverr)
		else $error("unmapped access accepted");
endmodule
bind sqa_arbiter sqa_arbiter_sva chk (
	.clk       (clk),
	.arst_n    (arst_n),
	.psel      (psel),
	.penable   (penable),
	.paddr     (paddr),
	.prdata    (prdata),
	.pslverr   (pslverr),
	.req       (req),
	.usb_level (usb_level),
	.dma_level (dma_level),
	.gnt       (gnt)
);

// file: test/sqa_masters.sv
// SRAM masters: each request holds until granted
`timescale 1ns/1ps
module sqa_masters
(
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic [4:0] ask,
	input wire logic [4:0] gnt,
	output logic     [4:0] req
);
	logic [4:0] held_r;
	assign req = held_r | ask;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			held_r <= '0;
		else
			held_r <= req & ~gnt;
endmodule

// file: test/test_sqa_arbiter.sv
// Self-checking bench for the SRAM arbiter
`timescale 1ns/1ps
module test_sqa_arbiter
	import sqa_pkg::*;
;
	logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rq[$];
	logic [3:0]  pstrb;
	logic [4:0]  req, ask, gnt, rm, pg, w, a, gq[$];
	logic [2:0]  lid;
	logic        eq[$];
	sqa_level_t  usb_level, dma_level, cl;
	int          n_fail, samples_checked;
	sqa_arbiter DUT (.*);
	sqa_masters far_end (.*);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task cmp_rd(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t read %h want %h", $time, got, exp);
		end
	endtask
	task cmp_gnt(input logic [4:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t grant %b want %b", $time, got, exp);
		end
	endtask
	task cmp_err(input logic got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t error %b want %b", $time, got, exp);
		end
	endtask
	task conclude;
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task apb(input logic wr, input logic [31:0] ad, d, x, input logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		if (!wr)
			rq.push_back(x);
		eq.push_back(e);
		do
			@(posedge clk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One arbitration cycle, predicted by level then port
	task step(input logic on);
		sqa_level_t lv[5];
		sqa_level_t b;
		@(posedge clk);
		a = on ? 5'($urandom & $urandom) : 5'h00;
		lv = '{cl, 2'h3, 2'h1, 2'($urandom), 2'($urandom)};
		w = rm & ~pg;
		rm = w | a;
		pg = '0;
		b = 2'h0;
		for (int i = 0; i < 5; i++)
			if (rm[i] && (lv[i][1] || w[i]) && (pg == 0 || lv[i] > b)) begin
				pg = 5'h01 << i;
				b = lv[i];
				lid = 3'(i);
			end
		ask <= a;
		usb_level <= lv[3];
		dma_level <= lv[4];
		gq.push_back(pg);
	endtask
	always @(posedge clk)
		if (psel && penable && pready) begin
			if (!pwrite)
				cmp_rd(prdata, rq.pop_front());
			cmp_err(pslverr, eq.pop_front());
		end
	always @(negedge clk)
		if (gq.size() > 0)
			cmp_gnt(gnt, gq.pop_front());
	initial begin
		{arst_n, psel, penable, pwrite, ask, usb_level, dma_level} = '0;
		{paddr, pwdata, rm, pg, cl, n_fail, samples_checked} = '0;
		pstrb = 4'hF;
		void'($urandom(32'h6D95674B));
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		apb(1'b0, ADDR_CPU_LVL, '0, '0, 1'b0);
		apb(1'b0, ADDR_STATUS, '0, '0, 1'b0);
		apb(1'b0, 32'h41007200, '0, '0, 1'b1);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			cl = 2'(k);
			apb(1'b1, ADDR_CPU_LVL, {30'($urandom), cl}, '0, 1'b0);
			pstrb <= 4'hE;
			apb(1'b1, ADDR_CPU_LVL, {30'h0, ~cl}, '0, 1'b0);
			pstrb <= 4'hF;
			apb(1'b0, ADDR_CPU_LVL, '0, {30'h0, cl}, 1'b0);
			repeat (60) step(1'b1);
			repeat (15) step(1'b0);
			apb(1'b0, ADDR_STATUS, '0, {29'h0, lid}, 1'b0);
			$display("test level %0d done", k);
		end
		conclude();
	end
	// Far beyond the few hundred cycles needed
	initial begin
		#20000;
		n_fail++;
		conclude();
	end
endmodule
